// file: pkg/pkt_cmd_defs.vh
// Notes on behaviour
// - type byte top bits: command, response, report, error
// - payload length zero to eighteen bytes
// - CRC16 over packet, low byte first
// - answer every packet within 250 ms; bad crc, over-length or non-command packets get no answer
// - fan reports every half second, four fans
// - temperature reports every second, 32 sensors
// - one reply per command, same code
// - ping echoes payload under type 0x40; payloads over 16 bytes get error 0xc0
// - version query returns sixteen byte string
// - sixteen byte user area, writes carry all
// - user area read returns stored bytes
// - load configuration from storage at power-up
// - store boot state saves settings, reply 0x44
// - reporting, fail-safe, watchdog never stored
// - boot state mismatch after save gives error
// - payload 8,18,99 restarts device
// - restart acknowledge delayed up to three seconds
// - fans started in sequence 500 ms apart
// - payload 12,28,97 acks, pulses host reset
// - after host reset, may ignore commands
// - payload 3,11,95 acks, powers host off
`ifndef PKT_CMD_DEFS_VH
`define PKT_CMD_DEFS_VH
`define CLK_HZ 40000000
`define CLK_KHZ 40000
`define T_HALF_MS 500
`define T_SEC_MS 1000
`define T_HOSTRST_MS 1500
`define T_BOOT_STEP_MS 500
`define CYC_HALF (`T_HALF_MS * `CLK_KHZ)
`define CYC_SEC (`T_SEC_MS * `CLK_KHZ)
`define CYC_HOSTRST (`T_HOSTRST_MS * `CLK_KHZ)
`define CYC_BOOT_STEP (`T_BOOT_STEP_MS * `CLK_KHZ)
`define TYPE_CMD 2'b00
`define TYPE_RSP 2'b01
`define TYPE_RPT 2'b10
`define TYPE_ERR 2'b11
`define MAX_LEN 8'h12
`define PING_MAX 8'h10
`define CODE_PING 6'h00
`define CODE_VER 6'h01
`define CODE_UWR 6'h02
`define CODE_URD 6'h03
`define CODE_STORE 6'h04
`define CODE_BOOT 6'h05
`define RPT_FAN 8'h81
`define RPT_TEMP 8'h82
`define USER_LEN 8'h10
`define CRC_POLY 16'h8408
`define CRC_INIT 16'hffff
`endif

// file: design/pkt_fifo.v
`timescale 1ns/100ps
module pkt_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk,
  input wire rstn,
  input wire ce,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_reg;
  reg [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  assign in_ready = !full;
  // no handover while frozen, or the far side would take a byte that is never popped
  assign out_valid = ce && !empty;
  assign out_data = mem[rd_reg[AW-1:0]];
  always @(posedge core_clk) begin
    if (!rstn) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (in_valid && !full) begin
        mem[wr_reg[AW-1:0]] <= in_data;
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready && !empty)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule // pkt_fifo

// file: design/packet_command_handler.v
`timescale 1ns/100ps
`include "pkt_cmd_defs.vh"
module packet_command_handler #(
  parameter HALF_CYC = `CYC_HALF,
  parameter SEC_CYC = `CYC_SEC,
  parameter HOSTRST_CYC = `CYC_HOSTRST,
  parameter BOOT_STEP_CYC = `CYC_BOOT_STEP,
  parameter [127:0] VERSION_STR = 128'h6465_7669_6365_3a68_312e_302c_7931_7630 // arbitrary
) (
  input wire core_clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  input wire [3:0] fan_report_en,
  input wire [31:0] temp_report_en,
  input wire [31:0] fan_data,
  input wire [511:0] temp_data,
  input wire [127:0] nv_user_rdata,
  output reg nv_user_we,
  output reg [127:0] nv_user_wdata,
  output reg nv_store_req,
  input wire nv_store_done,
  input wire nv_store_ok,
  output reg nv_load_req,
  input wire nv_load_done,
  output reg [3:0] fan_on,
  input wire [3:0] fan_boot_en,
  output reg host_reset_out,
  output reg host_reset_oe,
  output reg host_power_out,
  output reg host_power_oe,
  output reg busy
);
  localparam S_BOOT = 9'h001, S_IDLE = 9'h002, S_RX = 9'h004, S_EXEC = 9'h008, S_STORE = 9'h010;
  localparam S_TX = 9'h020, S_CRC = 9'h040, S_HRST = 9'h080, S_RESTART = 9'h100;
  localparam A_NONE = 2'd0, A_RESTART = 2'd1, A_HRST = 2'd2, A_POFF = 2'd3;
  reg [8:0] st_reg;
  // room for the low crc byte behind an 18-byte payload
  reg [7:0] buf_reg [0:20];
  reg [4:0] rx_idx_reg;
  reg [7:0] t_type_reg;
  reg [7:0] t_len_reg;
  reg [4:0] t_idx_reg;
  reg [15:0] crc_reg;
  reg [15:0] tcrc_reg;
  reg [1:0] act_reg;
  reg [31:0] tmr_reg;
  reg [2:0] boot_fan_reg;
  reg [31:0] half_reg;
  reg [31:0] sec_reg;
  reg [3:0] fan_pend_reg;
  reg [31:0] temp_pend_reg;
  reg [2:0] crc_ph_reg;
  reg [7:0] tx_byte_reg;
  reg tx_push_reg;
  wire fifo_ready;
  wire [7:0] ver_byte;
  wire [4:0] ver_pos;
  integer i;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1)
        x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
      crc_byte = x;
    end
  endfunction

  function [4:0] first_set32;
    input [31:0] v;
    integer k;
    begin
      first_set32 = 5'd0;
      for (k = 31; k >= 0; k = k - 1)
        if (v[k])
          first_set32 = k[4:0];
    end
  endfunction

  // nothing is taken while frozen, so ready drops with the enable
  assign rx_ready = ce && ((st_reg == S_IDLE) || (st_reg == S_RX));
  assign ver_pos = t_idx_reg - 5'd2;
  assign ver_byte = VERSION_STR[8'd127 - {ver_pos[3:0], 3'd0} -: 8];

  // bytes go through the fifo one packet at a time; a whole packet is framed before the next
  pkt_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .in_data(tx_byte_reg),
    .in_valid(tx_push_reg),
    .in_ready(fifo_ready),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  wire push_ok = !tx_push_reg || fifo_ready;
  wire [5:0] rx_code = buf_reg[0][5:0];
  wire [7:0] rx_len = buf_reg[1];
  wire [23:0] pat = {buf_reg[2], buf_reg[3], buf_reg[4]};
  wire [4:0] tsel = first_set32(temp_pend_reg);
  wire half_hit = (half_reg >= HALF_CYC - 1);
  wire sec_hit = (sec_reg >= SEC_CYC - 1);

  always @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= S_BOOT;
      rx_idx_reg <= 5'd0;
      t_type_reg <= 8'h00;
      t_len_reg <= 8'h00;
      t_idx_reg <= 5'd0;
      crc_reg <= `CRC_INIT;
      tcrc_reg <= `CRC_INIT;
      act_reg <= A_NONE;
      tmr_reg <= 32'd0;
      boot_fan_reg <= 3'd0;
      half_reg <= 32'd0;
      sec_reg <= 32'd0;
      fan_pend_reg <= 4'h0;
      temp_pend_reg <= 32'h0;
      crc_ph_reg <= 3'd0;
      tx_byte_reg <= 8'h00;
      tx_push_reg <= 1'b0;
      nv_user_we <= 1'b0;
      nv_user_wdata <= 128'h0;
      nv_store_req <= 1'b0;
      nv_load_req <= 1'b1;
      fan_on <= 4'h0;
      host_reset_out <= 1'b0;
      host_reset_oe <= 1'b1;
      host_power_out <= 1'b0;
      host_power_oe <= 1'b1;
      busy <= 1'b1;
      for (i = 0; i < 21; i = i + 1)
        buf_reg[i] <= 8'h00;
    end else if (ce) begin
      nv_user_we <= 1'b0;
      if (fifo_ready)
        tx_push_reg <= 1'b0;
      // report timers run in every state while ce is high; pending sets win over service clears
      if (half_hit) begin
        half_reg <= 32'd0;
        fan_pend_reg <= fan_pend_reg | fan_report_en;
      end else
        half_reg <= half_reg + 32'd1;
      if (sec_hit) begin
        sec_reg <= 32'd0;
        temp_pend_reg <= temp_pend_reg | temp_report_en;
      end else
        sec_reg <= sec_reg + 32'd1;
      case (st_reg)
        S_BOOT: begin
          // configuration load, then staggered fan start
          if (nv_load_req) begin
            if (nv_load_done)
              nv_load_req <= 1'b0;
          end else if (boot_fan_reg == 3'd4) begin
            busy <= 1'b0;
            st_reg <= S_IDLE;
          end else if (!fan_boot_en[boot_fan_reg[1:0]]) begin
            boot_fan_reg <= boot_fan_reg + 3'd1;
          end else if (tmr_reg == 32'd0 || fan_on == 4'h0) begin
            fan_on[boot_fan_reg[1:0]] <= 1'b1;
            boot_fan_reg <= boot_fan_reg + 3'd1;
            // counts down to zero, so the gap is one step, plus one cycle per skipped fan
            tmr_reg <= BOOT_STEP_CYC - 1;
          end else
            tmr_reg <= tmr_reg - 32'd1;
        end
        S_IDLE: begin
          if (rx_valid) begin
            buf_reg[0] <= rx_data;
            rx_idx_reg <= 5'd1;
            crc_reg <= crc_byte(`CRC_INIT, rx_data);
            st_reg <= S_RX;
          end else if (fan_pend_reg != 4'h0) begin
            t_type_reg <= `RPT_FAN;
            t_len_reg <= 8'h04;
            for (i = 3; i >= 0; i = i - 1)
              if (fan_pend_reg[i]) begin
                buf_reg[2] <= i[7:0];
                buf_reg[3] <= fan_data[i*8 +: 8];
                buf_reg[4] <= 8'h00;
                buf_reg[5] <= 8'h00;
              end
            fan_pend_reg <= (fan_pend_reg & (fan_pend_reg - 4'h1)) | (half_hit ? fan_report_en : 4'h0);
            act_reg <= A_NONE;
            t_idx_reg <= 5'd0;
            st_reg <= S_TX;
          end else if (temp_pend_reg != 32'h0) begin
            t_type_reg <= `RPT_TEMP;
            t_len_reg <= 8'h03;
            buf_reg[2] <= {3'd0, tsel};
            buf_reg[3] <= temp_data[{tsel, 4'd0} +: 8];
            buf_reg[4] <= temp_data[{tsel, 4'd8} +: 8];
            temp_pend_reg <= (temp_pend_reg & ~(32'h1 << tsel)) | (sec_hit ? temp_report_en : 32'h0);
            act_reg <= A_NONE;
            t_idx_reg <= 5'd0;
            st_reg <= S_TX;
          end
        end
        S_RX: begin
          if (rx_valid) begin
            if (rx_idx_reg == 5'd1 && rx_data > `MAX_LEN) begin
              st_reg <= S_IDLE;
            end else if (rx_idx_reg >= 5'd2 && rx_idx_reg == rx_len[4:0] + 5'd2 + 5'd1) begin
              // last crc byte, high half; low came first
              st_reg <= ({rx_data, buf_reg[rx_idx_reg - 5'd1]} == crc_reg && buf_reg[0][7:6] == `TYPE_CMD)
                        ? S_EXEC : S_IDLE;
            end else begin
              buf_reg[rx_idx_reg] <= rx_data;
              rx_idx_reg <= rx_idx_reg + 5'd1;
              if (rx_idx_reg < rx_len[4:0] + 5'd2 || rx_idx_reg == 5'd1)
                crc_reg <= crc_byte(crc_reg, rx_data);
            end
          end
        end
        S_EXEC: begin
          t_idx_reg <= 5'd0;
          act_reg <= A_NONE;
          t_len_reg <= 8'h00;
          t_type_reg <= {`TYPE_RSP, rx_code};
          st_reg <= S_TX;
          if (rx_code == `CODE_PING) begin
            if (rx_len > `PING_MAX)
              t_type_reg <= {`TYPE_ERR, rx_code};
            else
              t_len_reg <= rx_len;
          end else if (rx_code == `CODE_VER) begin
            if (rx_len != 8'h00)
              t_type_reg <= {`TYPE_ERR, rx_code};
            else
              t_len_reg <= 8'h10;
          end else if (rx_code == `CODE_UWR) begin
            if (rx_len != `USER_LEN)
              t_type_reg <= {`TYPE_ERR, rx_code};
            else begin
              nv_user_we <= 1'b1;
              for (i = 0; i < 16; i = i + 1)
                nv_user_wdata[i*8 +: 8] <= buf_reg[i+2];
            end
          end else if (rx_code == `CODE_URD) begin
            if (rx_len != 8'h00)
              t_type_reg <= {`TYPE_ERR, rx_code};
            else begin
              t_len_reg <= `USER_LEN;
              for (i = 0; i < 16; i = i + 1)
                buf_reg[i+2] <= nv_user_rdata[i*8 +: 8];
            end
          end else if (rx_code == `CODE_STORE) begin
            if (rx_len != 8'h00)
              t_type_reg <= {`TYPE_ERR, rx_code};
            else begin
              // store of saved settings; report enables are not in that set
              nv_store_req <= 1'b1;
              st_reg <= S_STORE;
            end
          end else if (rx_code == `CODE_BOOT) begin
            if (rx_len == 8'h03 && pat == 24'h081263)
              act_reg <= A_RESTART;
            else if (rx_len == 8'h03 && pat == 24'h0c1c61)
              act_reg <= A_HRST;
            else if (rx_len == 8'h03 && pat == 24'h030b5f)
              act_reg <= A_POFF;
            else
              t_type_reg <= {`TYPE_ERR, rx_code};
          end else
            t_type_reg <= {`TYPE_ERR, rx_code};
        end
        S_STORE: begin
          if (nv_store_done) begin
            nv_store_req <= 1'b0;
            if (!nv_store_ok)
              t_type_reg <= {`TYPE_ERR, rx_code};
            st_reg <= S_TX;
          end
        end
        S_TX: begin
          // framing: type, length, payload, then crc; sent without waiting on other work
          if (push_ok) begin
            tx_push_reg <= 1'b1;
            t_idx_reg <= t_idx_reg + 5'd1;
            if (t_idx_reg == 5'd0) begin
              tx_byte_reg <= t_type_reg;
              tcrc_reg <= crc_byte(`CRC_INIT, t_type_reg);
            end else if (t_idx_reg == 5'd1) begin
              tx_byte_reg <= t_len_reg;
              tcrc_reg <= crc_byte(tcrc_reg, t_len_reg);
            end else begin
              if (t_type_reg == {`TYPE_RSP, `CODE_VER}) begin
                tx_byte_reg <= ver_byte;
                tcrc_reg <= crc_byte(tcrc_reg, ver_byte);
              end else begin
                tx_byte_reg <= buf_reg[t_idx_reg];
                tcrc_reg <= crc_byte(tcrc_reg, buf_reg[t_idx_reg]);
              end
            end
            if (t_idx_reg + 5'd1 >= t_len_reg[4:0] + 5'd2 && t_idx_reg >= 5'd1) begin
              crc_ph_reg <= 3'd0;
              st_reg <= S_CRC;
            end
          end
        end
        S_CRC: begin
          if (push_ok) begin
            if (crc_ph_reg == 3'd0) begin
              tx_push_reg <= 1'b1;
              tx_byte_reg <= tcrc_reg[7:0];
              crc_ph_reg <= 3'd1;
            end else if (crc_ph_reg == 3'd1) begin
              tx_push_reg <= 1'b1;
              tx_byte_reg <= tcrc_reg[15:8];
              crc_ph_reg <= 3'd2;
            end else if (!tx_valid && !tx_push_reg) begin
              // wait for fifo to drain so the ack leaves before any action
              if (act_reg == A_RESTART) begin
                st_reg <= S_RESTART;
              end else if (act_reg == A_HRST) begin
                host_reset_out <= 1'b1;
                tmr_reg <= HOSTRST_CYC;
                busy <= 1'b1;
                st_reg <= S_HRST;
              end else begin
                if (act_reg == A_POFF)
                  host_power_out <= 1'b1;
                st_reg <= S_IDLE;
              end
            end
          end
        end
        S_HRST: begin
          if (tmr_reg == 32'd0) begin
            host_reset_out <= 1'b0;
            st_reg <= S_RESTART;
          end else
            tmr_reg <= tmr_reg - 32'd1;
        end
        S_RESTART: begin
          // power-on-like restart; commands refused until boot completes
          fan_on <= 4'h0;
          fan_pend_reg <= 4'h0;
          temp_pend_reg <= 32'h0;
          boot_fan_reg <= 3'd0;
          tmr_reg <= 32'd0;
          nv_load_req <= 1'b1;
          busy <= 1'b1;
          st_reg <= S_BOOT;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule // packet_command_handler

// file: tb/pch_chk.sv
`timescale 1ns/100ps
module pch_chk #(
  parameter BOOT_STEP_CYC = 20
) (
  input wire core_clk,
  input wire rstn,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire nv_user_we,
  input wire nv_store_req,
  input wire nv_store_done,
  input wire nv_load_req,
  input wire nv_load_done,
  input wire [3:0] fan_on,
  input wire [3:0] fan_boot_en,
  input wire host_reset_oe,
  input wire host_power_oe,
  input wire host_power_out,
  input wire busy
);
  reg [3:0] prev_reg;
  reg [31:0] gap_reg;
  // wide counter so a long run never wraps into a false gap
  always @(posedge core_clk) begin
    prev_reg <= rstn ? fan_on : 4'h0;
    if (!rstn || |(fan_on & ~prev_reg))
      gap_reg <= 32'h0;
    else
      gap_reg <= gap_reg + 32'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before taken");
  a_busy_no_rx: assert property (busy |-> !rx_ready)
    else $error("rx accepted while busy");
  a_we_one_cycle: assert property (nv_user_we |=> !nv_user_we)
    else $error("user write strobe too long");
  a_pins_driven: assert property (host_reset_oe && host_power_oe)
    else $error("power pins not driven");
  a_load_req_hold: assert property (nv_load_req && !nv_load_done |=> nv_load_req)
    else $error("load request dropped early");
  a_load_while_busy: assert property (nv_load_req |-> busy)
    else $error("not busy while loading");
  a_store_req_hold: assert property (nv_store_req && !nv_store_done |=> nv_store_req)
    else $error("store request dropped early");
  a_fan_one_step: assert property ($countones(fan_on & ~$past(fan_on)) <= 1)
    else $error("two fans started together");
  a_fan_gap_min: assert property (|(fan_on & ~prev_reg) && prev_reg != 4'h0 |-> gap_reg >= BOOT_STEP_CYC - 1)
    else $error("fans started too close");
  a_fan_boot_only: assert property ((fan_on & ~fan_boot_en) == 4'h0)
    else $error("fan on that boot config leaves off");
  a_power_off_held: assert property (host_power_out |=> host_power_out)
    else $error("power off released");
endmodule // pch_chk
bind packet_command_handler pch_chk #(.BOOT_STEP_CYC(BOOT_STEP_CYC)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .nv_user_we(nv_user_we), .nv_store_req(nv_store_req), .nv_store_done(nv_store_done),
  .nv_load_req(nv_load_req), .nv_load_done(nv_load_done), .fan_on(fan_on), .fan_boot_en(fan_boot_en),
  .host_reset_oe(host_reset_oe), .host_power_oe(host_power_oe), .host_power_out(host_power_out), .busy(busy)
);

// file: tb/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire core_clk,
  input wire rstn,
  output wire tx_ready,
  input wire nv_user_we,
  input wire [127:0] nv_user_wdata,
  output reg [127:0] nv_user_rdata,
  input wire nv_store_req,
  output reg nv_store_done,
  output reg nv_store_ok,
  input wire ok_in,
  input wire nv_load_req,
  output reg nv_load_done
);
  reg [1:0] tick_reg = 2'h0;
  reg [3:0] wait_reg = 4'h0;
  initial nv_user_rdata = 128'h0;
  initial nv_load_done = 1'b0;
  initial nv_store_done = 1'b0;
  initial nv_store_ok = 1'b0;
  // stall one cycle in three so the fifo really backs up
  assign tx_ready = tick_reg != 2'h2;
  always @(posedge core_clk) begin
    tick_reg <= (tick_reg == 2'h2) ? 2'h0 : tick_reg + 2'h1;
    nv_load_done <= 1'b0;
    nv_store_done <= 1'b0;
    nv_store_ok <= ~ok_in;
    if (nv_user_we)
      nv_user_rdata <= nv_user_wdata;
    if (!rstn)
      wait_reg <= 4'h0;
    else if ((nv_load_req | nv_store_req) & ~nv_load_done & ~nv_store_done) begin
      wait_reg <= wait_reg + 4'h1;
      if (wait_reg == 4'h5) begin
        wait_reg <= 4'h0;
        nv_load_done <= nv_load_req;
        nv_store_done <= nv_store_req;
        nv_store_ok <= ok_in;
      end
    end
  end
endmodule // host_model

// file: tb/packet_command_handler_test.sv
`timescale 1ns/100ps
`include "pkt_cmd_defs.vh"
module packet_command_handler_test;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] rx_data = 8'h00;
  reg rx_valid = 1'b0;
  reg [3:0] fan_report_en = 4'h0;
  reg [31:0] temp_report_en = 32'h0;
  reg ok_in = 1'b1;
  reg ce = 1'b1;
  reg [3:0] fan_boot_en = 4'h3;
  localparam [127:0] VER = 128'h7465_7374_2d76_6572_732d_7374_7269_6e67; // arbitrary
  wire rx_ready, tx_valid, tx_ready, nv_user_we, nv_store_req, nv_store_done, nv_store_ok;
  wire nv_load_req, nv_load_done, host_reset_out, host_reset_oe, host_power_out, host_power_oe, busy;
  wire [7:0] tx_data;
  wire [127:0] nv_user_rdata, nv_user_wdata;
  wire [3:0] fan_on;
  logic [7:0] q[$];
  logic [7:0] e[$];
  logic [7:0] r[$];
  integer miscompares = 0;
  integer comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  packet_command_handler #(.HALF_CYC(32'h28), .SEC_CYC(32'h50), .HOSTRST_CYC(32'h1e), .BOOT_STEP_CYC(32'h14),
    .VERSION_STR(VER)) DUT (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .fan_report_en(fan_report_en),
    .temp_report_en(temp_report_en), .fan_data(32'h44332211), .temp_data({416'h0, 16'h1234, 80'h0}),
    .nv_user_rdata(nv_user_rdata), .nv_user_we(nv_user_we), .nv_user_wdata(nv_user_wdata),
    .nv_store_req(nv_store_req), .nv_store_done(nv_store_done), .nv_store_ok(nv_store_ok),
    .nv_load_req(nv_load_req), .nv_load_done(nv_load_done), .fan_on(fan_on), .fan_boot_en(fan_boot_en),
    .host_reset_out(host_reset_out), .host_reset_oe(host_reset_oe), .host_power_out(host_power_out),
    .host_power_oe(host_power_oe), .busy(busy));
  host_model u_host (.core_clk(core_clk), .rstn(rstn), .tx_ready(tx_ready), .nv_user_we(nv_user_we),
    .nv_user_wdata(nv_user_wdata), .nv_user_rdata(nv_user_rdata), .nv_store_req(nv_store_req),
    .nv_store_done(nv_store_done), .nv_store_ok(nv_store_ok), .ok_in(ok_in), .nv_load_req(nv_load_req),
    .nv_load_done(nv_load_done));
  always @(posedge core_clk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      r.push_back(tx_data);
  function [15:0] crc(input [15:0] c, input [7:0] d);
    integer i;
    begin
      crc = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        crc = crc[0] ? (crc >> 1) ^ `CRC_POLY : crc >> 1;
    end
  endfunction
  function logic cond(input integer s);
    case (s)
      0: cond = busy === 1'b0;
      1: cond = host_reset_out === 1'b1;
      2: cond = host_power_out === 1'b1;
      default: cond = busy === 1'b1;
    endcase
  endfunction
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer s);
    integer n;
    begin
      n = 0;
      while (!cond(s) && n < 4000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      #1;
      cmp({7'h0, cond(s)}, 8'h01);
    end
  endtask
  task mk(input [7:0] ty, input integer n);
    integer i;
    begin
      e = {};
      for (i = 0; i < n; i = i + 1)
        e.push_back(8'ha0 + i[7:0]);
      q = {ty, n[7:0], e};
    end
  endtask
  task send;
    logic [15:0] c;
    integer i, n;
    begin
      c = `CRC_INIT;
      for (i = 0; i < q.size(); i = i + 1)
        c = crc(c, q[i]);
      q = {q, c[7:0], c[15:8]};
      for (i = 0; i < q.size(); i = i + 1) begin
        rx_data = q[i];
        rx_valid = 1'b1;
        n = 0;
        // ready is looked at settled, then the next edge takes the byte
        while (rx_ready !== 1'b1 && n < 4000) begin
          @(posedge core_clk);
          #1;
          n = n + 1;
        end
        @(posedge core_clk);
        #1;
      end
      rx_valid = 1'b0;
    end
  endtask
  task get(input [7:0] ty, input [7:0] len, input bit chk);
    logic [15:0] c;
    integer i, n;
    begin
      n = 0;
      while (r.size() < len + 4 && n < 5000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      #1;
      c = `CRC_INIT;
      for (i = 0; i < len + 2; i = i + 1)
        c = crc(c, r[i]);
      cmp(r[0], ty);
      cmp(r[1], len);
      for (i = 0; chk && i < len; i = i + 1)
        cmp(r[i + 2], e[i]);
      cmp(r[len + 2], c[7:0]);
      cmp(r[len + 3], c[15:8]);
      r = {};
    end
  endtask
  task t_cmds;
    integer i;
    begin
      mk(8'h00, 0);
      send;
      get(8'h40, 8'h00, 1);
      mk(8'h00, 16);
      send;
      get(8'h40, 8'h10, 1);
      mk(8'h01, 0);
      send;
      for (i = 0; i < 16; i = i + 1)
        e.push_back(VER[127 - 8 * i -: 8]);
      get(8'h41, 8'h10, 1);
      mk(8'h02, 16);
      send;
      get(8'h42, 8'h00, 0);
      cmp(nv_user_rdata[127:120], 8'haf);
      q = '{8'h03, 8'h00};
      send;
      get(8'h43, 8'h10, 1);
      $display("command test done");
    end
  endtask
  task t_bad;
    begin
      mk(8'h00, 17);
      send;
      get(8'hc0, 8'h00, 0);
      mk(8'h02, 15);
      send;
      get(8'hc2, 8'h00, 0);
      q = '{8'h05, 8'h03, 8'h01, 8'h02, 8'h03};
      send;
      get(8'hc5, 8'h00, 0);
      $display("bad packet test done");
    end
  endtask
  task t_store;
    begin
      mk(8'h04, 0);
      send;
      get(8'h44, 8'h00, 0);
      ok_in = 1'b0;
      mk(8'h04, 0);
      send;
      get(8'hc4, 8'h00, 0);
      ok_in = 1'b1;
      $display("store test done");
    end
  endtask
  task t_rpt;
    begin
      e = '{8'h01, 8'h22, 8'h00, 8'h00};
      ce = 1'b0;
      fan_report_en = 4'h2;
      // frozen for over two report periods: nothing may leave
      repeat (100) @(posedge core_clk);
      #1;
      cmp({7'h0, (r.size() == 0)}, 8'h01);
      ce = 1'b1;
      get(8'h81, 8'h04, 1);
      fan_report_en = 4'h0;
      repeat (100) @(posedge core_clk);
      #1;
      r = {};
      e = '{8'h05, 8'h34, 8'h12};
      temp_report_en = 32'h20;
      get(8'h82, 8'h03, 1);
      temp_report_en = 32'h0;
      repeat (100) @(posedge core_clk);
      #1;
      r = {};
      $display("report test done");
    end
  endtask
  task t_code5;
    begin
      // superset of the running fans, so no fan is on against the new config
      fan_boot_en = 4'hb;
      q = '{8'h05, 8'h03, 8'h08, 8'h12, 8'h63};
      send;
      get(8'h45, 8'h00, 0);
      wt(3);
      wt(0);
      cmp({4'h0, fan_on}, 8'h0b);
      q = '{8'h05, 8'h03, 8'h0c, 8'h1c, 8'h61};
      send;
      get(8'h45, 8'h00, 0);
      wt(1);
      wt(0);
      cmp({7'h0, host_reset_out}, 8'h00);
      q = '{8'h05, 8'h03, 8'h03, 8'h0b, 8'h5f};
      send;
      get(8'h45, 8'h00, 0);
      wt(2);
      cmp({6'h0, host_reset_oe, host_power_oe}, 8'h03);
      $display("restart test done");
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #(25 * 30000);
    miscompares = miscompares + 1;
    close_out;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    cmp({7'h0, nv_load_req}, 8'h01);
    rstn = 1'b1;
    wt(0);
    cmp({4'h0, fan_on}, 8'h03);
    t_cmds;
    t_bad;
    t_store;
    t_rpt;
    t_code5;
    close_out;
  end
endmodule // packet_command_handler_test
